//--- design/srse_cfg.svh
`ifndef SRSE_CFG_SVH
`define SRSE_CFG_SVH
// ----------------------------------------
// Sync/reset pin, in master clock periods
// ----------------------------------------
`define SRSE_RST_LOW_CLKS 12'h800
`define SRSE_SYNC_MAX_CLKS 12'h7FF
// ----------------------------------------
// Sample ready pulse, in master clock periods
// ----------------------------------------
`define SRSE_RDY_HI_CLKS 3'h4
`define SRSE_RDY_LO_CLKS 3'h4
// ----------------------------------------
// Serial port
// ----------------------------------------
`define SRSE_SPI_TMO_CLKS 16'h8000
`define SRSE_SPI_BITS 4'h8
// ----------------------------------------
// Start-up times
// ----------------------------------------
`define SRSE_CORE_NS 10
`define SRSE_POR_US 250
`define SRSE_REGACQ_US 5
`define SRSE_POR_CYC (`SRSE_POR_US * 1000 / `SRSE_CORE_NS)
`define SRSE_REGACQ_CYC (`SRSE_REGACQ_US * 1000 / `SRSE_CORE_NS)
`endif

//--- design/srse_pkg.sv
`default_nettype none
package srse_pkg;
	typedef enum logic [3:0] {
		SRSE_ST_LOAD = 4'h1,
		SRSE_ST_POR = 4'h2,
		SRSE_ST_RUN = 4'h4,
		SRSE_ST_PINRST = 4'h8
	} srse_state_t;
endpackage : srse_pkg
`default_nettype wire

//--- design/srse_spi_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "srse_cfg.svh"
module srse_spi_port (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic mclk_rise,
	input wire logic sclk,
	input wire logic cs_b,
	input wire logic mosi,
	input wire logic [7:0] tx_data,
	output logic miso_r,
	output logic miso_oe_r,
	output logic [7:0] rx_data_r,
	output logic rx_valid_r
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic sclk_d_r;
	logic cs_d_r;
	logic [7:0] tx_sh_r;
	logic [7:0] rx_sh_r;
	logic [3:0] bit_r;
	logic [15:0] tmo_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= 3'h2;
			s2_r <= 3'h2;
			sclk_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			s1_r <= {mosi, cs_b, sclk};
			s2_r <= s1_r;
			sclk_d_r <= s2_r[0];
			cs_d_r <= s2_r[1];
		end
	end
	wire sclk_s = s2_r[0];
	wire cs_s = s2_r[1];
	wire mosi_s = s2_r[2];
	wire sel = !cs_s && !clr;
	wire sclk_rise = sel && sclk_s && !sclk_d_r;
	wire sclk_fall = sel && !sclk_s && sclk_d_r;
	wire cs_fall = !cs_s && cs_d_r;
	wire cs_rise = cs_s && !cs_d_r;
	wire last_bit = sclk_fall && (bit_r == `SRSE_SPI_BITS - 4'h1);
	// Idle time counts only on master edges, so a slow host is fine
	wire tmo_hit = mclk_rise && (bit_r != 4'h0)
		&& (tmo_r == `SRSE_SPI_TMO_CLKS - 16'h1);
	// ----------------------------------------
	// Shift logic
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			miso_oe_r <= 1'b0;
			miso_r <= 1'b0;
			tx_sh_r <= 8'h00;
		end else begin
			if (cs_rise || clr)
				miso_oe_r <= 1'b0;
			else if (cs_fall)
				miso_oe_r <= 1'b1;
			if (cs_fall || last_bit)
				tx_sh_r <= tx_data;
			else if (sclk_rise) begin
				miso_r <= tx_sh_r[7];
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			end
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_sh_r <= 8'h00;
			bit_r <= 4'h0;
			rx_data_r <= 8'h00;
			rx_valid_r <= 1'b0;
			tmo_r <= 16'h0000;
		end else begin
			rx_valid_r <= last_bit;
			if (cs_fall || tmo_hit || clr) begin
				bit_r <= 4'h0;
				rx_sh_r <= 8'h00;
			end else if (sclk_fall) begin
				rx_sh_r <= {rx_sh_r[6:0], mosi_s};
				bit_r <= last_bit ? 4'h0 : bit_r + 4'h1;
			end
			if (last_bit)
				rx_data_r <= {rx_sh_r[6:0], mosi_s};
			if (sclk_fall || bit_r == 4'h0 || tmo_hit)
				tmo_r <= 16'h0000;
			else if (mclk_rise)
				tmo_r <= tmo_r + 16'h1;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_capture_on_fall: assert property (
		sclk_fall && !last_bit |=> rx_sh_r[0] == $past(mosi_s))
		else $error("bit not captured on falling edge");
	a_launch_on_rise: assert property (
		sclk_rise && !last_bit |=> miso_r == $past(tx_sh_r[7])
		##1 (miso_r == $past(miso_r) || $past(sclk_rise)))
		else $error("output bit not launched or held");
	a_drive_after_cs: assert property (
		$rose(miso_oe_r) |-> $past(cs_fall))
		else $error("output driven without chip select");
	a_release_on_cs: assert property (
		cs_rise |=> !miso_oe_r)
		else $error("output not released");
	a_frame_timeout: assert property (
		tmo_hit && !sclk_fall |=> bit_r == 4'h0)
		else $error("stale frame kept");
	c_byte_done: cover property (rx_valid_r);
	c_timeout: cover property (tmo_hit);
endmodule : srse_spi_port
`default_nettype wire

//--- design/srse_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "srse_cfg.svh"
// Function
// - Low for 2048 master periods resets device
// - Low for 1 to 2047 periods synchronises
// - Pin sampled on master clock rising edges
// - Serial input captured on falling clock edge
// - Serial output launched after rising edge
// - Output driven only after chip select falls
// - Output released after chip select rises
// - First sample ready 250 us after power
// - Register defaults load for 5 us
// - Clock idles low, shift rise, capture fall
module srse_top #(
	parameter int POR_CYC = `SRSE_POR_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic MASTER_CLOCK_INPUT,
	input wire logic SYNC_RESET_B,
	input wire logic SAMPLE_TICK,
	input wire logic SPI_SCLK,
	input wire logic SPI_CS_B,
	input wire logic SPI_MOSI,
	input wire logic [7:0] TX_DATA,
	output logic SAMPLE_READY_OUT,
	output logic SYNC_REQ,
	output logic DEVICE_RESET,
	output logic REGS_VALID,
	output logic SPI_MISO_O,
	output logic SPI_MISO_OE,
	output logic [7:0] RX_DATA,
	output logic RX_VALID
);
	localparam int REGACQ_I = `SRSE_REGACQ_CYC;
	localparam logic [15:0] REGACQ_CYC = 16'(REGACQ_I);
	// POR wait includes the register load, so only the rest is counted
	localparam logic [15:0] POR_REST = 16'(POR_CYC - REGACQ_I);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic mck_s1_r;
	logic mck_s2_r;
	logic mck_d_r;
	logic pin_s1_r;
	logic pin_s2_r;
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mck_s1_r <= 1'b0;
			mck_s2_r <= 1'b0;
			mck_d_r <= 1'b0;
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
		end else begin
			mck_s1_r <= MASTER_CLOCK_INPUT;
			mck_s2_r <= mck_s1_r;
			mck_d_r <= mck_s2_r;
			pin_s1_r <= SYNC_RESET_B;
			pin_s2_r <= pin_s1_r;
		end
	end
	wire mclk_rise = mck_s2_r && !mck_d_r;
	// ----------------------------------------
	// Sync/reset pin low-time
	// ----------------------------------------
	logic [11:0] low_r;
	logic [11:0] low_nxt;
	logic sync_req_r;
	srse_pkg::srse_state_t st_r;
	srse_pkg::srse_state_t st_nxt;
	wire pin_low_edge = mclk_rise && !pin_s2_r;
	wire pin_high_edge = mclk_rise && pin_s2_r;
	wire low_sat = (low_r == `SRSE_RST_LOW_CLKS);
	wire rst_hit = pin_low_edge
		&& (low_r == `SRSE_RST_LOW_CLKS - 12'h1);
	// Short pulses only; a finished reset never doubles as a sync
	wire sync_hit = pin_high_edge && (low_r != 12'h000)
		&& (low_r <= `SRSE_SYNC_MAX_CLKS)
		&& (st_r != srse_pkg::SRSE_ST_PINRST);
	assign low_nxt = pin_high_edge ? 12'h000 :
		(pin_low_edge && !low_sat) ? low_r + 12'h1 : low_r;
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			low_r <= 12'h000;
			sync_req_r <= 1'b0;
		end else begin
			low_r <= low_nxt;
			sync_req_r <= sync_hit;
		end
	end
	// ----------------------------------------
	// Reset and start-up sequence
	// ----------------------------------------
	logic [15:0] wait_r;
	logic [15:0] wait_nxt;
	logic por_pend_r;
	logic dev_rst_r;
	logic regs_ok_r;
	wire load_done = (st_r == srse_pkg::SRSE_ST_LOAD)
		&& (wait_r == REGACQ_CYC - 16'h1);
	wire por_done = (st_r == srse_pkg::SRSE_ST_POR)
		&& (wait_r == POR_REST - 16'h1);
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			srse_pkg::SRSE_ST_PINRST:
				if (pin_high_edge)
					st_nxt = srse_pkg::SRSE_ST_LOAD;
			srse_pkg::SRSE_ST_LOAD:
				if (load_done)
					st_nxt = por_pend_r ? srse_pkg::SRSE_ST_POR
						: srse_pkg::SRSE_ST_RUN;
			srse_pkg::SRSE_ST_POR:
				if (por_done)
					st_nxt = srse_pkg::SRSE_ST_RUN;
			srse_pkg::SRSE_ST_RUN: ;
		endcase
		if (rst_hit)
			st_nxt = srse_pkg::SRSE_ST_PINRST;
	end
	assign wait_nxt = (st_nxt != st_r) ? 16'h0000 : wait_r + 16'h1;
	wire regs_ok_nxt = (st_nxt == srse_pkg::SRSE_ST_POR)
		|| (st_nxt == srse_pkg::SRSE_ST_RUN);
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_r <= srse_pkg::SRSE_ST_LOAD;
			wait_r <= 16'h0000;
			por_pend_r <= 1'b1;
			dev_rst_r <= 1'b0;
			regs_ok_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			wait_r <= wait_nxt;
			if (rst_hit || load_done)
				por_pend_r <= 1'b0;
			dev_rst_r <= (st_nxt == srse_pkg::SRSE_ST_PINRST);
			regs_ok_r <= regs_ok_nxt;
		end
	end
	// ----------------------------------------
	// Sample ready pulse
	// ----------------------------------------
	logic rdy_r;
	logic lo_busy_r;
	logic pend_r;
	logic [2:0] dcnt_r;
	wire run = (st_r == srse_pkg::SRSE_ST_RUN);
	wire new_evt = por_done || (run && SAMPLE_TICK);
	wire hi_end = rdy_r && (dcnt_r == `SRSE_RDY_HI_CLKS - 3'h1);
	wire lo_end = lo_busy_r && (dcnt_r == `SRSE_RDY_LO_CLKS - 3'h1);
	wire start = !rdy_r && !lo_busy_r && pend_r;
	wire stop = !regs_ok_r;
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdy_r <= 1'b0;
			lo_busy_r <= 1'b0;
			pend_r <= 1'b0;
			dcnt_r <= 3'h0;
		end else if (stop) begin
			rdy_r <= 1'b0;
			lo_busy_r <= 1'b0;
			pend_r <= 1'b0;
			dcnt_r <= 3'h0;
		end else begin
			// A tick landing on the start edge stays pending
			if (new_evt)
				pend_r <= 1'b1;
			else if (mclk_rise && start)
				pend_r <= 1'b0;
			if (mclk_rise) begin
				if (hi_end || lo_end || start)
					dcnt_r <= 3'h0;
				else if (rdy_r || lo_busy_r)
					dcnt_r <= dcnt_r + 3'h1;
				if (hi_end) begin
					rdy_r <= 1'b0;
					lo_busy_r <= 1'b1;
				end else if (lo_end)
					lo_busy_r <= 1'b0;
				else if (start)
					rdy_r <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// Serial port
	// ----------------------------------------
	// Relies on the host moving chip select with the clock low
	srse_spi_port u_spi (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.clr(stop),
		.mclk_rise(mclk_rise),
		.sclk(SPI_SCLK),
		.cs_b(SPI_CS_B),
		.mosi(SPI_MOSI),
		.tx_data(TX_DATA),
		.miso_r(SPI_MISO_O),
		.miso_oe_r(SPI_MISO_OE),
		.rx_data_r(RX_DATA),
		.rx_valid_r(RX_VALID)
	);
	assign SAMPLE_READY_OUT = rdy_r;
	assign SYNC_REQ = sync_req_r;
	assign DEVICE_RESET = dev_rst_r;
	assign REGS_VALID = regs_ok_r;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	a_reset_entry: assert property (
		rst_hit |=> DEVICE_RESET && $past(low_r) == 12'h7FF)
		else $error("long low did not reset");
	a_sync_range: assert property (
		SYNC_REQ |-> $past(low_r) != 12'h000
		&& $past(low_r) <= 12'h7FF && !DEVICE_RESET)
		else $error("sync pulse out of range");
	a_pin_sample: assert property (
		low_r != $past(low_r) |-> $past(mclk_rise))
		else $error("low count moved off master edge");
	a_por_time: assert property (
		por_done |=> pend_r && run)
		else $error("first sample ready not armed");
	a_regs_load: assert property (
		$rose(REGS_VALID) |-> $past(load_done))
		else $error("registers valid too early");
	a_ready_high: assert property (
		$fell(SAMPLE_READY_OUT) && !$past(stop)
		|-> $past(dcnt_r) == 3'h3 && $past(mclk_rise))
		else $error("sample ready high time wrong");
	c_pin_reset: cover property (rst_hit);
	c_sync: cover property (SYNC_REQ);
	c_ready: cover property ($rose(SAMPLE_READY_OUT));
endmodule : srse_top
`default_nettype wire

//--- testbench/srse_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module srse_host_model (
	input wire logic clk,
	input wire logic miso,
	input wire logic miso_oe,
	output logic sclk,
	output logic cs_b,
	output logic mosi
);
	// Released line reads inverted so a dropped enable shows up
	logic line;
	assign line = miso_oe ? miso : !miso;
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		mosi = 1'b0;
	end
	// ----------------------------------------
	// Frame tasks, 80 ns half period
	// ----------------------------------------
	task automatic half();
		repeat (8) @(posedge clk);
	endtask : half
	// Chip select moves only with clock low
	task automatic select();
		@(posedge clk);
		cs_b <= 1'b0;
		half();
	endtask : select
	// Idles low, shift on rise, capture on fall
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx,
		output logic oe_all);
		int i;
		oe_all = 1'b1;
		for (i = 7; i >= 0; i--) begin
			sclk <= 1'b1;
			mosi <= tx[i];
			half();
			rx[i] = line;
			oe_all = oe_all & miso_oe;
			sclk <= 1'b0;
			half();
		end
	endtask : xbyte
	// Host output data line flips on deselect so no stale bit survives
	task automatic deselect();
		cs_b <= 1'b1;
		mosi <= ~mosi;
		half();
	endtask : deselect
endmodule : srse_host_model
`default_nettype wire

//--- testbench/srse_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module srse_top_bench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic mclk = 1'b0;
	logic pin_b = 1'b1;
	logic tick = 1'b0;
	logic [7:0] tx = 8'h00;
	logic [2:0] mdiv = 3'h0;
	logic sclk, cs_b, mosi;
	logic rdy, sreq, drst, rvalid, miso, oe, rxv;
	logic [7:0] rxd;
	logic [7:0] rxq[$];
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int syncs = 0;
	always #5 clk = ~clk;
	// Master clock 160 ns, unrelated to the serial frames
	always @(posedge clk) begin
		mdiv <= mdiv + 3'h1;
		if (mdiv == 3'h7) mclk <= ~mclk;
		if (sreq === 1'b1) syncs++;
		if (rxv === 1'b1) rxq.push_back(rxd);
		cycles++;
		if (cycles == 90000) begin
			errors++;
			conclude();
		end
	end
	srse_top #(.POR_CYC(600)) DUT (.CORE_CLK(clk), .RST_B(rst_b),
		.MASTER_CLOCK_INPUT(mclk), .SYNC_RESET_B(pin_b), .SAMPLE_TICK(tick),
		.SPI_SCLK(sclk), .SPI_CS_B(cs_b), .SPI_MOSI(mosi), .TX_DATA(tx),
		.SAMPLE_READY_OUT(rdy), .SYNC_REQ(sreq), .DEVICE_RESET(drst),
		.REGS_VALID(rvalid), .SPI_MISO_O(miso), .SPI_MISO_OE(oe),
		.RX_DATA(rxd), .RX_VALID(rxv));
	srse_host_model host (.clk(clk), .miso(miso), .miso_oe(oe),
		.sclk(sclk), .cs_b(cs_b), .mosi(mosi));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t: %s seen %0h want %0h", $time, what, seen,
				exp);
		end
	endtask : check
	task automatic wait_lvl(ref logic s, input logic v, output int n);
		n = 0;
		while (s !== v && n < 40000) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_lvl
	task automatic pin_low(input int n);
		pin_b <= 1'b0;
		repeat (n) @(posedge clk);
		pin_b <= 1'b1;
	endtask : pin_low
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_startup();
		int n, m;
		wait_lvl(rvalid, 1'b1, n);
		check(n >= 498 && n <= 504, 1'b1, "regs load time");
		wait_lvl(rdy, 1'b1, m);
		check(n + m >= 600 && n + m <= 624, 1'b1, "first ready");
	endtask : t_startup
	task automatic t_ready();
		int n;
		wait_lvl(rdy, 1'b0, n);
		tick <= 1'b1;
		repeat (2) @(posedge clk);
		tick <= 1'b0;
		wait_lvl(rdy, 1'b1, n);
		wait_lvl(rdy, 1'b0, n);
		check(n, 64, "ready high");
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		wait_lvl(rdy, 1'b1, n);
		check(n >= 64, 1'b1, "ready low");
		wait_lvl(rdy, 1'b0, n);
		repeat (100) @(posedge clk);
		check(rdy, 1'b0, "merged ticks");
	endtask : t_ready
	task automatic t_spi();
		logic [7:0] r;
		logic ok;
		rxq.delete();
		check(oe, 1'b0, "oe idle");
		tx <= 8'hA5;
		host.select();
		tx <= 8'h5A;
		host.xbyte(8'h3C, r, ok);
		check(r, 8'hA5, "out byte 1");
		check(ok, 1'b1, "oe in frame");
		host.xbyte(8'hC3, r, ok);
		check(r, 8'h5A, "out byte 2");
		host.deselect();
		check(oe, 1'b0, "oe released");
		check(rxq.size(), 2, "byte count");
		if (rxq.size() == 2) begin
			check(rxq[0], 8'h3C, "in byte 1");
			check(rxq[1], 8'hC3, "in byte 2");
		end
	endtask : t_spi
	// Low between two master edges is never seen
	task automatic t_glitch();
		int s;
		s = syncs;
		while (!(mdiv === 3'h4 && mclk === 1'b1)) @(posedge clk);
		pin_low(6);
		repeat (60) @(posedge clk);
		check(syncs - s, 0, "glitch");
	endtask : t_glitch
	task automatic t_sync(input int n);
		int s;
		s = syncs;
		pin_low(n);
		repeat (80) @(posedge clk);
		check(syncs - s, 1, "sync pulse");
		check(drst, 1'b0, "no reset");
	endtask : t_sync
	task automatic t_reset();
		int s, n;
		s = syncs;
		pin_b <= 1'b0;
		repeat (2060 * 16) @(posedge clk);
		check(drst, 1'b1, "pin reset");
		check(rvalid, 1'b0, "regs cleared");
		pin_b <= 1'b1;
		repeat (40) @(posedge clk);
		check(drst, 1'b0, "reset end");
		check(syncs - s, 0, "no sync on reset");
		wait_lvl(rvalid, 1'b1, n);
		// Pin sync and wait for a master edge add 3 to 18 cycles
		check(n >= 464 && n <= 479, 1'b1, "regs reload");
	endtask : t_reset
	initial begin
		repeat (4) @(posedge clk);
		check(drst, 1'b0, "reset outputs");
		rst_b <= 1'b1;
		t_startup();
		t_ready();
		t_spi();
		t_glitch();
		t_sync(48);
		t_sync(2000 * 16);
		t_reset();
		conclude();
	end
endmodule : srse_top_bench
`default_nettype wire
